// File: logic/fspc_pkg.sv
// Purpose: constants and carriers for the flash security and protection block
// Assumes: APB with 32-bit data, byte registers in the low bits of each word
// Notes:   key window is eight word slots, one key byte each
package fspc_pkg;
    localparam int        AW            = 8;
    localparam int        DW            = 32;
    localparam [AW-1:0]   OFS_OPT       = 8'h00;
    localparam [AW-1:0]   OFS_CFG       = 8'h04;
    localparam [AW-1:0]   OFS_PROT      = 8'h08;
    localparam [AW-1:0]   OFS_STAT      = 8'h0C;
    localparam [AW-1:0]   OFS_KEY0      = 8'h10;
    localparam [AW-1:0]   OFS_KEYN      = 8'h2C;
    localparam int        KEY_BYTES     = 8;
    localparam [3:0]      KEY_FULL      = 4'h8;
    localparam [15:0]     KEY_CPU_BASE  = 16'hFFB0;
    localparam int        OPT_BACKDOOR_ENABLE     = 7;
    localparam int        OPT_NORED     = 6;
    localparam [7:0]      OPT_RD_MASK   = 8'hC3;
    localparam [1:0]      SEC_UNSEC     = 2'h2;
    localparam int        CFG_KEYSEL    = 5;
    localparam [7:0]      CFG_RW_MASK   = 8'hE0;
    localparam [7:0]      CFG_RST       = 8'h00;
    localparam int        PROT_OFF      = 0;
    localparam int        PAGE_LSB      = 9;
    localparam int        STAT_VIOL     = 0;
    localparam int        STAT_SEC      = 1;
    localparam int        STAT_KEYSEQ   = 2;

    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } fspc_apb_req_type;

    typedef struct packed {
        logic [DW-1:0] prdata;
        logic          pready;
        logic          pslverr;
    } fspc_apb_rsp_type;

    typedef struct packed {
        logic        launch;
        logic        modifies;
        logic [15:0] addr;
    } fspc_cmd_type;

    typedef struct packed {
        logic        start;
        logic [15:0] addr;
        logic [7:0]  data;
    } fspc_kwin_type;

    typedef enum logic [0:0] {
        KEY_IDLE    = 1'b0,
        KEY_COLLECT = 1'b1
    } fspc_key_state_type;
endpackage : fspc_pkg

// File: logic/fspc_flash_sec_prot.sv
// Purpose: flash option shadow, security decode, backdoor key and block protection
// Assumes: debugSrc qualifies the current APB transfer; nv images are static
// Notes:   one wait state on every APB transfer
// Notes on behaviour
// R1: each reset copies the options image into the options shadow.
// R2: options shadow bits 5 to 2 always read zero.
// R3: bus writes to options shadow are ignored; change needs reprogram plus reset.
// R4: backdoor key cannot unlock while backdoor enable bit is zero.
// R5: only firmware key writes count; debug host key writes are dropped.
// R6: eight matching key bytes in ascending order unlock until next reset.
// R7: redirect disable bit one turns vector redirection off.
// R8: only security code 1:0 means unsecured; others are secured.
// R9: while secured, unsecured sources get no memory access.
// R10: key unlock or clean blank check forces security code to 1:0.
// R11: config bits 7 to 5 read/write; bits 4 to 0 read zero.
// R12: key-select zero makes key window writes start flash commands.
// R13: key-select one captures key window writes as key bytes only.
// R14: each reset copies protection image into protection shadow; always readable.
// R15: with protection on, only a smaller boundary may be written.
// R16: with protection off, writes do not change protection.
// R17: boundary bits 7:1 mark end of unprotected flash, protected at top.
// R18: program or erase inside the protected region is refused.
// R19: protection-off one protects nothing; zero protects the selected block.
// R20: firmware sets key-select, writes eight bytes, then clears it to compare.
// R21: protection shadow is writable only by debug host commands.
// R22: a program or erase command hitting protected flash is dropped and sets violation flag.
// R23: both shadows are loaded while reset is held.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module fspc_flash_sec_prot (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire fspc_pkg::fspc_apb_req_type apbReq,
    input  wire logic                      debugSrc,
    input  wire logic [7:0]                optionsNvImage,
    input  wire logic [7:0]                protectionNvImage,
    input  wire logic [63:0]               backdoorKeyStore,
    input  wire logic                      untrustedReq,
    input  wire fspc_pkg::fspc_cmd_type     cmdIn,
    input  wire logic                      blankCheckOk,
    output var fspc_pkg::fspc_apb_rsp_type  apbRsp,
    output logic                           secured,
    output logic                           redirectDisable,
    output logic                           untrustedGrant,
    output logic                           cmdGo,
    output logic                           violationFlag,
    output var fspc_pkg::fspc_kwin_type     keyWinCmd
);
    import fspc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]         optShadow_ff;
    logic [7:0]         nxt_optShadow;
    logic [7:0]         cfg_ff;
    logic [7:0]         nxt_cfg;
    logic [7:0]         prot_ff;
    logic [7:0]         nxt_prot;
    logic               viol_ff;
    logic               nxt_viol;
    fspc_apb_rsp_type   rsp_ff;
    fspc_apb_rsp_type   nxt_rsp;
    fspc_key_state_type keyState_ff;
    fspc_key_state_type nxt_keyState;
    logic [3:0]         keyCnt_ff;
    logic [3:0]         nxt_keyCnt;
    logic               keyBad_ff;
    logic               nxt_keyBad;
    logic [7:0]         keyBuf_ff [KEY_BYTES];
    logic [7:0]         nxt_keyBuf [KEY_BYTES];
    logic               sec_ff;
    logic               nxt_sec;
    logic               nored_ff;
    logic               nxt_nored;
    logic               grant_ff;
    logic               nxt_grant;
    logic               go_ff;
    logic               nxt_go;
    fspc_kwin_type      kwin_ff;
    fspc_kwin_type      nxt_kwin;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    logic          access;
    logic          wrDone;
    logic          isKey;
    logic [AW-1:0] keyOfs;
    logic [2:0]    keyIdx;
    logic          mapped;
    logic          wrOpt;
    logic          wrCfg;
    logic          wrProt;
    logic          wrStat;
    logic          wrKey;
    logic          keySel;
    logic          keySelFall;
    logic          keyMatch;
    logic          keyUnlock;
    logic          protHit;
    logic [7:0]    rdByte;

    assign access  = apbReq.psel & apbReq.penable;
    assign wrDone  = access & rsp_ff.pready & apbReq.pwrite;
    assign keyOfs  = apbReq.paddr - OFS_KEY0;
    assign keyIdx  = keyOfs[4:2];
    assign isKey   = (apbReq.paddr >= OFS_KEY0) && (apbReq.paddr <= OFS_KEYN)
                     && (apbReq.paddr[1:0] == 2'h0);
    assign mapped  = isKey || (apbReq.paddr == OFS_OPT) || (apbReq.paddr == OFS_CFG)
                     || (apbReq.paddr == OFS_PROT) || (apbReq.paddr == OFS_STAT);
    assign wrOpt   = wrDone && (apbReq.paddr == OFS_OPT);
    assign wrCfg   = wrDone && (apbReq.paddr == OFS_CFG);
    assign wrProt  = wrDone && (apbReq.paddr == OFS_PROT) && debugSrc; // R21
    assign wrStat  = wrDone && (apbReq.paddr == OFS_STAT);
    assign wrKey   = wrDone && isKey;
    assign keySel  = cfg_ff[CFG_KEYSEL];
    assign keySelFall = wrCfg && keySel && !apbReq.pwdata[CFG_KEYSEL]; // R20

    ////////////////////////////////////////////////////////////////////
    // key comparison
    always_comb begin
        keyMatch = 1'b1;
        for (int i = 0; i < KEY_BYTES; i++) begin
            if (keyBuf_ff[i] != backdoorKeyStore[8*i +: 8]) begin
                keyMatch = 1'b0;
            end
        end
    end

    // R4 R6
    assign keyUnlock = keySelFall && (keyState_ff == KEY_COLLECT)
                       && optShadow_ff[OPT_BACKDOOR_ENABLE] && !keyBad_ff
                       && (keyCnt_ff == KEY_FULL) && keyMatch;

    always_comb begin
        nxt_keyState = keyState_ff;
        nxt_keyCnt   = keyCnt_ff;
        nxt_keyBad   = keyBad_ff;
        for (int i = 0; i < KEY_BYTES; i++) begin
            nxt_keyBuf[i] = keyBuf_ff[i];
        end
        case (keyState_ff)
            KEY_IDLE: begin
                if (wrCfg && apbReq.pwdata[CFG_KEYSEL]) begin
                    nxt_keyState = KEY_COLLECT;
                    nxt_keyCnt   = 4'h0;
                    nxt_keyBad   = 1'b0;
                end
            end
            KEY_COLLECT: begin
                if (wrKey && !debugSrc) begin // R5 R13
                    nxt_keyBuf[keyIdx] = apbReq.pwdata[7:0];
                    if ((keyCnt_ff == KEY_FULL) || ({1'b0, keyIdx} != keyCnt_ff)) begin
                        nxt_keyBad = 1'b1; // R6
                    end else begin
                        nxt_keyCnt = keyCnt_ff + 4'h1;
                    end
                end
                if (keySelFall) begin
                    nxt_keyState = KEY_IDLE;
                end
            end
            default: begin
                nxt_keyState = KEY_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // option shadow, config and protection
    always_comb begin
        nxt_optShadow = optShadow_ff; // R3
        if (keyUnlock || blankCheckOk) begin
            nxt_optShadow[1:0] = SEC_UNSEC; // R10
        end
        nxt_cfg = cfg_ff;
        if (wrCfg) begin
            nxt_cfg = apbReq.pwdata[7:0] & CFG_RW_MASK; // R11
        end
        nxt_prot = prot_ff;
        if (wrProt && !prot_ff[PROT_OFF]) begin // R16
            if (apbReq.pwdata[7:1] < prot_ff[7:1]) begin
                nxt_prot[7:1] = apbReq.pwdata[7:1]; // R15
            end
        end
        nxt_sec   = (nxt_optShadow[1:0] != SEC_UNSEC); // R8
        nxt_nored = nxt_optShadow[OPT_NORED]; // R7
    end

    ////////////////////////////////////////////////////////////////////
    // commands, key window and memory gate
    // R17 R19
    assign protHit = !prot_ff[PROT_OFF] && (cmdIn.addr[15:PAGE_LSB] > prot_ff[7:1]);

    always_comb begin
        nxt_go    = cmdIn.launch && !(cmdIn.modifies && protHit); // R18
        nxt_viol  = viol_ff;
        if (wrStat && apbReq.pwdata[STAT_VIOL]) begin
            nxt_viol = 1'b0;
        end
        if (cmdIn.launch && cmdIn.modifies && protHit) begin
            nxt_viol = 1'b1; // R22
        end
        nxt_grant = untrustedReq && !sec_ff; // R9
        nxt_kwin  = kwin_ff;
        nxt_kwin.start = 1'b0;
        if (wrKey && !keySel) begin // R12
            nxt_kwin.start = 1'b1;
            nxt_kwin.addr  = KEY_CPU_BASE + {13'h0000, keyIdx};
            nxt_kwin.data  = apbReq.pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux and response
    always_comb begin
        rdByte = 8'h00;
        if (apbReq.paddr == OFS_OPT) begin
            rdByte = optShadow_ff & OPT_RD_MASK; // R2
        end else if (apbReq.paddr == OFS_CFG) begin
            rdByte = cfg_ff & CFG_RW_MASK;
        end else if (apbReq.paddr == OFS_PROT) begin
            rdByte = prot_ff; // R14
        end else if (apbReq.paddr == OFS_STAT) begin
            rdByte[STAT_VIOL]   = viol_ff;
            rdByte[STAT_SEC]    = sec_ff;
            rdByte[STAT_KEYSEQ] = (keyState_ff == KEY_COLLECT);
        end
    end

    always_comb begin
        nxt_rsp         = rsp_ff;
        nxt_rsp.pready  = 1'b0;
        nxt_rsp.pslverr = 1'b0;
        if (access && !rsp_ff.pready) begin
            nxt_rsp.pready  = 1'b1;
            nxt_rsp.pslverr = !mapped;
            nxt_rsp.prdata  = {24'h0000_00, rdByte};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            optShadow_ff <= optionsNvImage & OPT_RD_MASK; // R1 R23
            prot_ff      <= protectionNvImage; // R14 R23
            sec_ff       <= (optionsNvImage[1:0] != SEC_UNSEC);
            nored_ff     <= optionsNvImage[OPT_NORED];
            cfg_ff       <= CFG_RST;
            viol_ff      <= 1'b0;
            rsp_ff       <= '0;
            keyState_ff  <= KEY_IDLE;
            keyCnt_ff    <= 4'h0;
            keyBad_ff    <= 1'b0;
            grant_ff     <= 1'b0;
            go_ff        <= 1'b0;
            kwin_ff      <= '0;
            for (int i = 0; i < KEY_BYTES; i++) begin
                keyBuf_ff[i] <= 8'h00;
            end
        end else begin
            optShadow_ff <= nxt_optShadow;
            prot_ff      <= nxt_prot;
            sec_ff       <= nxt_sec;
            nored_ff     <= nxt_nored;
            cfg_ff       <= nxt_cfg;
            viol_ff      <= nxt_viol;
            rsp_ff       <= nxt_rsp;
            keyState_ff  <= nxt_keyState;
            keyCnt_ff    <= nxt_keyCnt;
            keyBad_ff    <= nxt_keyBad;
            grant_ff     <= nxt_grant;
            go_ff        <= nxt_go;
            kwin_ff      <= nxt_kwin;
            for (int i = 0; i < KEY_BYTES; i++) begin
                keyBuf_ff[i] <= nxt_keyBuf[i];
            end
        end
    end

    assign apbRsp          = rsp_ff;
    assign secured         = sec_ff;
    assign redirectDisable = nored_ff;
    assign untrustedGrant  = grant_ff;
    assign cmdGo           = go_ff;
    assign violationFlag   = viol_ff;
    assign keyWinCmd       = kwin_ff;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_opt_unused_zero: assert property ( // R2
        (optShadow_ff & ~OPT_RD_MASK) == 8'h00
    ) else $error("options shadow unused bits set");

    chk_opt_write_ignored: assert property ( // R3
        wrOpt && !keyUnlock && !blankCheckOk |=> $stable(optShadow_ff)
    ) else $error("options shadow changed by bus write");

    chk_key_enable_gate: assert property ( // R4
        keyUnlock |-> optShadow_ff[OPT_BACKDOOR_ENABLE]
    ) else $error("key unlock with backdoor disabled");

    chk_debug_key_drop: assert property ( // R5
        wrKey && debugSrc |=> $stable(keyCnt_ff) && $stable(keyBad_ff)
    ) else $error("debug key write counted");

    chk_unlock_code: assert property ( // R10
        keyUnlock || blankCheckOk |=> (optShadow_ff[1:0] == SEC_UNSEC) && !secured
    ) else $error("unlock did not clear security");

    chk_sec_decode: assert property ( // R8
        secured == (optShadow_ff[1:0] != SEC_UNSEC)
    ) else $error("security decode mismatch");

    chk_cfg_low_zero: assert property ( // R11
        cfg_ff[4:0] == 5'h00
    ) else $error("config low bits set");

    chk_kwin_start: assert property ( // R12
        wrKey && !keySel |=> keyWinCmd.start ##1 !keyWinCmd.start
    ) else $error("key window command start wrong");

    chk_kwin_capture: assert property ( // R13
        wrKey && keySel |=> !keyWinCmd.start
    ) else $error("command started in key mode");

    chk_prot_grow: assert property ( // R15
        prot_ff[7:1] <= $past(prot_ff[7:1])
    ) else $error("protection boundary grew");

    chk_prot_off_hold: assert property ( // R16
        prot_ff[PROT_OFF] |=> $stable(prot_ff)
    ) else $error("protection changed while off");

    chk_prot_violation: assert property ( // R22
        cmdIn.launch && cmdIn.modifies && protHit |=> violationFlag && !cmdGo
    ) else $error("protected command not refused");

    chk_apb_wait_one: assert property (
        access && !apbRsp.pready |=> apbRsp.pready
    ) else $error("apb ready late");

    chk_untrusted_gate: assert property ( // R9
        secured |=> !untrustedGrant
    ) else $error("untrusted access while secured");

    chk_opt_reset_load: assert property ( // R1 R23
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> optShadow_ff == ($past(optionsNvImage) & OPT_RD_MASK)
    ) else $error("options shadow not loaded at reset");

    chk_prot_reset_load: assert property ( // R14 R23
        @(posedge clk) disable iff (1'b0)
        sys_rst |=> prot_ff == $past(protectionNvImage)
    ) else $error("protection shadow not loaded at reset");

    chk_redirect_map: assert property ( // R7
        redirectDisable == optShadow_ff[OPT_NORED]
    ) else $error("redirect disable not from options shadow");

    chk_prot_off_go: assert property ( // R19
        cmdIn.launch && prot_ff[PROT_OFF] |=> cmdGo
    ) else $error("command refused while protection off");

    chk_prot_region: assert property ( // R17 R18
        cmdIn.launch && cmdIn.modifies && !prot_ff[PROT_OFF]
        && (cmdIn.addr[15:PAGE_LSB] > prot_ff[7:1]) |=> !cmdGo
    ) else $error("command inside protected region accepted");

    chk_prot_debug_only: assert property ( // R21
        wrDone && (apbReq.paddr == OFS_PROT) && !debugSrc |=> $stable(prot_ff)
    ) else $error("protection changed by firmware write");

    chk_key_bad_hold: assert property ( // R6
        keySelFall && keyBad_ff && !blankCheckOk |=> $stable(optShadow_ff)
    ) else $error("spoilt key sequence changed security");

    chk_opt_read_zero: assert property ( // R2
        access && !apbRsp.pready && (apbReq.paddr == OFS_OPT) |=> apbRsp.prdata[5:2] == 4'h0
    ) else $error("options shadow unused bits read nonzero");

    chk_prot_readable: assert property ( // R14
        access && !apbRsp.pready && (apbReq.paddr == OFS_PROT)
        |=> apbRsp.prdata[7:0] == $past(prot_ff)
    ) else $error("protection shadow read wrong");
endmodule : fspc_flash_sec_prot
`default_nettype wire

// File: tb/fspc_nv_model.sv
// Purpose: nonvolatile image and key store behind the flash security block
// Assumes: images change only by an erase and reprogram pulse
// Notes:   new images take effect at the next reset of the block
`timescale 1ns/10ps
`default_nettype none
module fspc_nv_model #(
    parameter logic [63:0] KEY = 64'h0123_4567_89AB_CDEF
) (
    input  wire logic        clk,
    input  wire logic        reprogram,
    input  wire logic [7:0]  optNext,
    input  wire logic [7:0]  protNext,
    output logic      [7:0]  optionsNvImage,
    output logic      [7:0]  protectionNvImage,
    output logic      [63:0] backdoorKeyStore
);
    logic [7:0] optFf  = 8'h00;
    logic [7:0] protFf = 8'h00;

    // erase and reprogram of both images
    always @(posedge clk) begin
        if (reprogram) begin
            optFf  <= optNext;
            protFf <= protNext;
        end
    end

    assign optionsNvImage    = optFf;
    assign protectionNvImage = protFf;
    assign backdoorKeyStore  = KEY;
endmodule : fspc_nv_model
`default_nettype wire

// File: tb/tb_flash_security_protection_cfg.sv
// Purpose: self-checking bench for the flash security and protection block
// Assumes: one wait state APB answer, registered side outputs
// Notes:   reads and key-window commands are checked from queues
`timescale 1ns/10ps
`default_nettype none
module tb_flash_security_protection_cfg;
    import fspc_pkg::*;
    localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
    logic             clk, sys_rst, debugSrc, untrustedReq, blankCheckOk, reprogram;
    logic [7:0]       optNext, protNext, optImg, protImg;
    logic [63:0]      keyStore;
    fspc_apb_req_type req;
    fspc_apb_rsp_type rsp;
    fspc_cmd_type     cmd;
    fspc_kwin_type    kwin;
    logic             secured, redirectDisable, untrustedGrant, cmdGo, violationFlag;
    logic [32:0]      rdQ[$];
    logic [32:0]      kwQ[$];
    logic [31:0]      rnd;
    int               error_cnt;
    int               total_checks;

    fspc_nv_model #(.KEY(KEY)) u_nv (.clk(clk), .reprogram(reprogram), .optNext(optNext),
        .protNext(protNext), .optionsNvImage(optImg), .protectionNvImage(protImg),
        .backdoorKeyStore(keyStore));
    fspc_flash_sec_prot u_dut (.clk(clk), .sys_rst(sys_rst), .apbReq(req), .debugSrc(debugSrc),
        .optionsNvImage(optImg), .protectionNvImage(protImg), .backdoorKeyStore(keyStore),
        .untrustedReq(untrustedReq), .cmdIn(cmd), .blankCheckOk(blankCheckOk), .apbRsp(rsp),
        .secured(secured), .redirectDisable(redirectDisable), .untrustedGrant(untrustedGrant),
        .cmdGo(cmdGo), .violationFlag(violationFlag), .keyWinCmd(kwin));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    task automatic chkv(input string n, input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chkv

    task automatic chk1(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic final_report();
        if (rdQ.size() != 0 || kwQ.size() != 0) error_cnt++;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic dbg);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h00_0000, d}};
        debugSrc <= dbg;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            error_cnt++;
            final_report();
        end
        req <= '0;
        debugSrc <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err);
        rdQ.push_back({err, 24'h00_0000, e});
        apb(1'b0, a, 8'h00, 1'b0);
    endtask : rd

    task automatic keyEntry(input logic [63:0] k, input logic dbg);
        apb(1'b1, OFS_CFG, 8'h20, 1'b0);
        for (int i = 0; i < KEY_BYTES; i++) apb(1'b1, OFS_KEY0 + 8'(4 * i), k[8*i +: 8], dbg);
        apb(1'b1, OFS_CFG, 8'h00, 1'b0);
        repeat (2) @(posedge clk);
        #1;
    endtask : keyEntry

    task automatic cmdT(input logic [15:0] a, input logic m, input logic go, input logic vi);
        cmd <= '{launch: 1'b1, modifies: m, addr: a};
        @(posedge clk);
        cmd.launch <= 1'b0;
        #1;
        chk1("cmdGo", go, cmdGo);
        chk1("violationFlag", vi, violationFlag);
        @(posedge clk);
    endtask : cmdT

    task automatic rstSeq(input logic [7:0] o, input logic [7:0] p);
        optNext <= o;
        protNext <= p;
        reprogram <= 1'b1;
        @(posedge clk);
        reprogram <= 1'b0;
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk1("redirectDisable", o[OPT_NORED], redirectDisable);
        chk1("secured", o[1:0] != SEC_UNSEC, secured);
        @(posedge clk);
    endtask : rstSeq

    ////////////////////////////////////////////////////////////////////////////////
    // read answers and key-window command starts
    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
            chkv("read", rdQ.size() > 0 ? rdQ.pop_front() : 33'hx, {rsp.pslverr, rsp.prdata});
        end
        if (!sys_rst && kwin.start !== 1'b0) begin
            chkv("keyWinCmd", kwQ.size() > 0 ? kwQ.pop_front() : 33'hx, {9'h000, kwin.addr, kwin.data});
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #400000;
        error_cnt++;
        final_report();
    end

    initial begin
        sys_rst = 1'b1;
        debugSrc = 1'b0;
        untrustedReq = 1'b1;
        blankCheckOk = 1'b0;
        reprogram = 1'b0;
        optNext = 8'h00;
        protNext = 8'h00;
        req = '0;
        cmd = '0;
        error_cnt = 0;
        total_checks = 0;
        rnd = xs(32'h0000_005D);
        @(posedge clk);
        rstSeq((rnd[7:0] | 8'h80) & 8'hFC, 8'h80);
        chk1("untrustedGrant", 1'b0, untrustedGrant);
        rd(OFS_OPT, optImg & OPT_RD_MASK, 1'b0);
        apb(1'b1, OFS_OPT, 8'hFF, 1'b0);
        rd(OFS_OPT, optImg & OPT_RD_MASK, 1'b0);
        apb(1'b1, OFS_CFG, 8'hFF, 1'b0);
        rd(OFS_CFG, CFG_RW_MASK, 1'b0);
        apb(1'b1, OFS_CFG, 8'h00, 1'b0);
        kwQ.push_back({9'h000, KEY_CPU_BASE + 16'h0003, 8'h5A});
        apb(1'b1, OFS_KEY0 + 8'h0C, 8'h5A, 1'b0);
        rd(8'hF0, 8'h00, 1'b1);
        keyEntry(KEY, 1'b1);
        chk1("secured", 1'b1, secured);
        @(posedge clk);
        keyEntry(KEY ^ 64'h0000_0000_0000_0100, 1'b0);
        chk1("secured", 1'b1, secured);
        @(posedge clk);
        keyEntry(KEY, 1'b0);
        chk1("secured", 1'b0, secured);
        chk1("untrustedGrant", 1'b1, untrustedGrant);
        @(posedge clk);
        untrustedReq <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk1("untrustedGrant", 1'b0, untrustedGrant);
        @(posedge clk);
        untrustedReq <= 1'b1;
        rd(OFS_STAT, 8'h00, 1'b0);
        rnd = xs(rnd);
        rstSeq(rnd[7:0] & 8'h7C, 8'h80);
        keyEntry(KEY, 1'b0);
        chk1("secured", 1'b1, secured);
        @(posedge clk);
        blankCheckOk <= 1'b1;
        @(posedge clk);
        blankCheckOk <= 1'b0;
        #1;
        chk1("secured", 1'b0, secured);
        @(posedge clk);
        cmdT(16'h81FF, 1'b1, 1'b1, 1'b0);
        cmdT(16'h8200, 1'b1, 1'b0, 1'b1);
        cmdT(16'hFFFF, 1'b0, 1'b1, 1'b1);
        rd(OFS_STAT, 8'h01, 1'b0);
        apb(1'b1, OFS_STAT, 8'h01, 1'b0);
        rd(OFS_STAT, 8'h00, 1'b0);
        apb(1'b1, OFS_PROT, 8'h40, 1'b0);
        rd(OFS_PROT, 8'h80, 1'b0);
        apb(1'b1, OFS_PROT, 8'h90, 1'b1);
        rd(OFS_PROT, 8'h80, 1'b0);
        apb(1'b1, OFS_PROT, 8'h40, 1'b1);
        rd(OFS_PROT, 8'h40, 1'b0);
        cmdT(16'h4000, 1'b1, 1'b1, 1'b0);
        cmdT(16'h4200, 1'b1, 1'b0, 1'b1);
        rstSeq(optImg, 8'h01);
        rd(OFS_PROT, 8'h01, 1'b0);
        cmdT(16'hFE00, 1'b1, 1'b1, 1'b0);
        apb(1'b1, OFS_PROT, 8'h20, 1'b1);
        rd(OFS_PROT, 8'h01, 1'b0);
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule : tb_flash_security_protection_cfg
`default_nettype wire
